// ---- radio_cfg_defs.svh ----
`ifndef RADIO_CFG_DEFS_SVH
`define RADIO_CFG_DEFS_SVH

// -----------------------------------------------------------------------------
// Control input positions (bus index 0..7 maps to pins 8..15)
// -----------------------------------------------------------------------------
`define CTL_TX_RX          3'd0
`define CTL_MODULATION     3'd1
`define CTL_SLEEP          3'd2
`define CTL_START_VECTOR   3'd3
`define CTL_SPREAD         3'd4
`define CTL_ALT_SPREAD     3'd5
`define CTL_RX_RATE        3'd6
`define CTL_ENHANCED_SEL   3'd7

// -----------------------------------------------------------------------------
// Serial timing and framing
// -----------------------------------------------------------------------------
`define SER_HALF_NS        100
`define CLK_PERIOD_NS      20
`define SER_HALF_CYC       ((`SER_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SER_BYTE_BITS      8
`define RATE_CODE_4K8      2'h1
`define RATE_CODE_19K2     2'h2

`endif

// ---- radio_cfg_pkg.sv ----
package radio_cfg_pkg;
    typedef enum logic [1:0] {LEG_SLEEP, LEG_TX_OOK, LEG_TX_ASK, LEG_RX} legacy_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_GAP} ser_state_t;
endpackage

// ---- radio_mode_config_front_end.sv ----
`timescale 1ns/1ps
`include "radio_cfg_defs.svh"

// What this block does
// [R01] Legacy mode: controller idle, pins external.
// [R02] Enhanced mode: sample eight inputs, detect changes.
// [R03] Change triggers automatic serial register rewrite.
// [R04] Enhanced mode: controller alone drives serial lines.
// [R05] Legacy mode: clock/data pins are inputs.
// [R06] Decode legacy bits A,B into radio mode.
// [R07] Mode latched once after power-up only.
// [R08] Enable grounded legacy; chip select enhanced.
// [R09] Host raises enhanced select after power-up.
// [R10] No serial traffic until enhanced select high.
// [R11] Host pattern for ASK 19.2 kb/s receive.
// [R12] Host pattern for ASK 4.8 kb/s vector.
// [R13] Host toggles start vector to re-arm.
// [R14] Recovered clock low until start; held till disable.
// [R15] Each eight serial bits form one register.
// [R16] Data changes on falling, captured on rising.
// [R17] Rate select high 4.8, low 19.2.
// [R18] Simultaneous changes give one full snapshot.
module radio_mode_config_front_end #(
    parameter int CTRL_W = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_powerup_mode_jumper,
    input  wire logic [CTRL_W-1:0] i_ctrl,
    input  wire logic              i_serial_config_clock,
    input  wire logic              i_serial_config_data,
    input  wire logic              i_start_symbol,
    input  wire logic              i_slicer_data,
    input  wire logic              i_recovery_tick,
    output logic                   o_enhanced_mode,
    output logic [1:0]             o_legacy_op,
    output logic [1:0]             o_rx_rate,
    output logic                   o_config_enable,
    output logic                   o_serial_config_clock,
    output logic                   o_serial_config_clock_oe_n,
    output logic                   o_serial_config_data,
    output logic                   o_serial_config_data_oe_n,
    output logic                   o_recovered_clock_out,
    output logic                   o_recovered_data_out
);

    localparam int HALF_CYC = `SER_HALF_CYC;
    localparam int CNT_W    = (HALF_CYC < 2) ? 1 : $clog2(HALF_CYC);

    // -------------------------------------------------------------------------
    // Reset release and power-up mode capture
    // -------------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;
    default clocking chk_cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_n_q);

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // The jumper is sampled once after release; later moves are ignored.
    logic mode_taken_q;
    logic enh_q;
    // [R07] latch mode once
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            mode_taken_q <= 1'b0;
            enh_q        <= 1'b0;
        end
        else if (!mode_taken_q)
        begin
            mode_taken_q <= 1'b1;
            enh_q        <= i_powerup_mode_jumper;
        end
    end

    logic armed_q;
    // [R10] wait for enhanced select
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            armed_q <= 1'b0;
        else if (mode_taken_q && enh_q && i_ctrl[`CTL_ENHANCED_SEL])
            armed_q <= 1'b1;
    end

    // -------------------------------------------------------------------------
    // Legacy decode and rate select
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            o_legacy_op     <= 2'h0;
            o_rx_rate       <= 2'h0;
            o_enhanced_mode <= 1'b0;
        end
        else
        begin
            o_enhanced_mode <= mode_taken_q && enh_q;
            // [R06] decode bits A,B
            if (mode_taken_q && !enh_q)
                case ({i_serial_config_data, i_serial_config_clock})
                    2'b00:   o_legacy_op <= radio_cfg_pkg::LEG_SLEEP;
                    2'b01:   o_legacy_op <= radio_cfg_pkg::LEG_TX_OOK;
                    2'b10:   o_legacy_op <= radio_cfg_pkg::LEG_TX_ASK;
                    default: o_legacy_op <= radio_cfg_pkg::LEG_RX;
                endcase
            // [R17] rate select
            else if (armed_q)
                o_rx_rate <= i_ctrl[`CTL_RX_RATE] ? `RATE_CODE_4K8 : `RATE_CODE_19K2;
        end
    end

    // -------------------------------------------------------------------------
    // Change detection and serial writer
    // -------------------------------------------------------------------------
    logic [CTRL_W-1:0]   last_q;
    logic                pending_q;
    logic [CTRL_W-1:0]   shift_q;
    logic [2:0]          bit_q;
    logic [CNT_W-1:0]    tim_q;
    radio_cfg_pkg::ser_state_t st_q;
    logic                tim_done;
    assign tim_done = (tim_q == CNT_W'(HALF_CYC - 1));

    // [R02] detect input change
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            last_q    <= '0;
            pending_q <= 1'b0;
        end
        else if (armed_q)
        begin
            last_q <= i_ctrl;
            // An idle writer takes its snapshot at this edge, so only busy changes wait.
            if (st_q == radio_cfg_pkg::ST_IDLE)
                pending_q <= 1'b0;
            else if (i_ctrl != last_q)
                pending_q <= 1'b1;
        end
    end

    // [R03] automatic rewrite
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            st_q    <= radio_cfg_pkg::ST_IDLE;
            shift_q <= '0;
            bit_q   <= 3'h0;
            tim_q   <= '0;
        end
        else
        begin
            case (st_q)
                radio_cfg_pkg::ST_IDLE:
                begin
                    tim_q <= '0;
                    bit_q <= 3'h0;
                    // [R18] full snapshot
                    if (armed_q && (pending_q || i_ctrl != last_q))
                    begin
                        shift_q <= i_ctrl;
                        st_q    <= radio_cfg_pkg::ST_LOW;
                    end
                end
                radio_cfg_pkg::ST_LOW:
                begin
                    tim_q <= tim_done ? '0 : tim_q + 1'b1;
                    if (tim_done)
                        st_q <= radio_cfg_pkg::ST_HIGH;
                end
                radio_cfg_pkg::ST_HIGH:
                begin
                    tim_q <= tim_done ? '0 : tim_q + 1'b1;
                    // [R15] eight bits per register
                    if (tim_done)
                    begin
                        shift_q <= {shift_q[CTRL_W-2:0], 1'b0};
                        bit_q   <= bit_q + 3'h1;
                        st_q    <= (bit_q == 3'(`SER_BYTE_BITS - 1)) ?
                                   radio_cfg_pkg::ST_GAP : radio_cfg_pkg::ST_LOW;
                    end
                end
                default:
                begin
                    tim_q <= tim_done ? '0 : tim_q + 1'b1;
                    if (tim_done)
                        st_q <= radio_cfg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Pin drivers and recovered clock
    // -------------------------------------------------------------------------
    // Legacy mode releases both pins so the host owns the mode bits.
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            o_config_enable            <= 1'b0;
            o_serial_config_clock      <= 1'b0;
            o_serial_config_data       <= 1'b0;
            o_serial_config_clock_oe_n <= 1'b1;
            o_serial_config_data_oe_n  <= 1'b1;
        end
        else
        begin
            // [R01] [R05] release in legacy
            o_serial_config_clock_oe_n <= !(mode_taken_q && enh_q);
            o_serial_config_data_oe_n  <= !(mode_taken_q && enh_q);
            // [R08] chip select / ground
            o_config_enable <= enh_q && (st_q == radio_cfg_pkg::ST_LOW ||
                                         st_q == radio_cfg_pkg::ST_HIGH);
            // [R04] [R16] drive clock and data
            o_serial_config_clock <= enh_q && (st_q == radio_cfg_pkg::ST_HIGH);
            o_serial_config_data  <= enh_q && shift_q[CTRL_W-1];
        end
    end

    logic rec_active_q;
    // [R14] gate recovered clock
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rec_active_q          <= 1'b0;
            o_recovered_clock_out <= 1'b0;
            o_recovered_data_out  <= 1'b0;
        end
        else
        begin
            if (!(armed_q && i_ctrl[`CTL_START_VECTOR]))
                rec_active_q <= 1'b0;
            else if (i_start_symbol)
                rec_active_q <= 1'b1;
            o_recovered_clock_out <= rec_active_q && i_ctrl[`CTL_START_VECTOR]
                                     && i_recovery_tick;
            o_recovered_data_out  <= i_slicer_data;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    property p_legacy_quiet;
        (mode_taken_q && !enh_q) |=> (o_serial_config_clock_oe_n && !o_config_enable);
    endproperty
    a_legacy_quiet: assert property (p_legacy_quiet) else $error("legacy drive seen"); // [R01]
    property p_idle_before_arm;
        !armed_q |-> st_q == radio_cfg_pkg::ST_IDLE;
    endproperty
    a_idle_before_arm: assert property (p_idle_before_arm) else $error("early traffic"); // [R10]
    property p_change_starts;
        (armed_q && st_q == radio_cfg_pkg::ST_IDLE && i_ctrl != last_q)
        |=> st_q == radio_cfg_pkg::ST_LOW;
    endproperty
    a_change_starts: assert property (p_change_starts) else $error("no rewrite"); // [R03]
    property p_mode_fixed;
        mode_taken_q |=> $stable(enh_q);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed"); // [R07]
    property p_rec_low;
        !rec_active_q |=> !o_recovered_clock_out;
    endproperty
    a_rec_low: assert property (p_rec_low) else $error("clock before start"); // [R14]
    property p_rate;
        (armed_q && i_ctrl[`CTL_RX_RATE]) |=> o_rx_rate == `RATE_CODE_4K8;
    endproperty
    a_rate: assert property (p_rate) else $error("rate wrong"); // [R17]
    property p_byte_len;
        $rose(st_q == radio_cfg_pkg::ST_GAP) |-> $past(bit_q) == 3'h7;
    endproperty
    a_byte_len: assert property (p_byte_len) else $error("byte length"); // [R15]
    property p_legacy_decode;
        (mode_taken_q && !enh_q && i_serial_config_clock && !i_serial_config_data)
        |=> o_legacy_op == radio_cfg_pkg::LEG_TX_OOK;
    endproperty
    a_legacy_decode: assert property (p_legacy_decode) else $error("decode wrong"); // [R06]
endmodule

// ---- radio_mode_config_front_end_bench.sv ----
`timescale 1ns/1ps
module radio_mode_config_front_end_bench;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       jumper = 1'b0;
    logic [7:0] ctrl = 8'h00;
    logic       start_sym = 1'b0;
    logic       slicer = 1'b0;
    logic       tick = 1'b0;
    logic [1:0] leg_bits = 2'h0;
    logic       pin_clk, pin_dat, byte_valid, enh, cs, dclk, dclk_oe_n, ddat, ddat_oe_n;
    logic       rclk, rdat;
    logic [1:0] leg_op, rate;
    logic [7:0] rx_byte, v;
    logic [7:0] exp_q[$];
    // host set-up patterns
    // Select goes high first, then both receive set-ups and the start-vector re-arm toggle.
    logic [7:0] setups [5] = '{8'h82, 8'hca, 8'hc2, 8'hca, 8'h81};
    int         errors = 0;
    int         total_checks = 0;
    int         cycles = 0;

    always #10 clk = ~clk;

    radio_mode_config_front_end i_radio_mode_config_front_end (
        .i_clk(clk), .i_resetn(resetn), .i_powerup_mode_jumper(jumper), .i_ctrl(ctrl),
        .i_serial_config_clock(pin_clk), .i_serial_config_data(pin_dat),
        .i_start_symbol(start_sym), .i_slicer_data(slicer), .i_recovery_tick(tick),
        .o_enhanced_mode(enh), .o_legacy_op(leg_op), .o_rx_rate(rate), .o_config_enable(cs),
        .o_serial_config_clock(dclk), .o_serial_config_clock_oe_n(dclk_oe_n),
        .o_serial_config_data(ddat), .o_serial_config_data_oe_n(ddat_oe_n),
        .o_recovered_clock_out(rclk), .o_recovered_data_out(rdat));

    radio_port_model i_radio_port_model (
        .i_clk(clk), .i_cs(cs), .i_drv_clk(dclk), .i_drv_clk_oe_n(dclk_oe_n),
        .i_drv_dat(ddat), .i_drv_dat_oe_n(ddat_oe_n), .i_leg_bits(leg_bits),
        .o_pin_clk(pin_clk), .o_pin_dat(pin_dat), .o_byte_valid(byte_valid), .o_byte(rx_byte));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic do_reset(input logic jmp);
        @(negedge clk);
        resetn = 1'b0;
        jumper = jmp;
        ctrl = 8'h00;
        cyc(8);
        resetn = 1'b1;
        cyc(6);
    endtask

    // Queue first, so the watcher never sees a byte before its note.
    task automatic put(input logic [7:0] nv);
        exp_q.push_back(nv);
        ctrl = nv;
    endtask

    task automatic drain();
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 600)
        begin
            cyc(1);
            k++;
        end
        cyc(12);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (byte_valid === 1'b1 && exp_q.size() == 0)
            check("unexpected byte", 8'h00, 8'h01);
        else if (byte_valid === 1'b1)
            check("config byte", exp_q.pop_front(), rx_byte);
        if (cycles == 20000)
        begin
            errors++;
            finish_test();
        end
    end

    initial
    begin
        void'($urandom(26644));
        do_reset(1'b0);
        for (int i = 0; i < 4; i++)
        begin
            leg_bits = i[1:0];
            ctrl = 8'($urandom);
            tick = 1'($urandom);
            cyc(3);
            check("legacy op", {6'h0, i[1:0]}, {6'h0, leg_op});
            check("legacy pins", 8'h03, {5'h0, cs, dclk_oe_n, ddat_oe_n});
        end
        jumper = 1'b1;
        cyc(200);
        check("mode", 8'h00, {7'h0, enh});
        do_reset(1'b1);
        check("mode", 8'h01, {7'h0, enh});
        ctrl = 8'h45;
        cyc(150);
        check("idle cs", 8'h00, {7'h0, cs});
        for (int j = 0; j < 8; j++)
        begin
            v = (j < 5) ? setups[j] : (ctrl ^ (8'($urandom) | 8'h01)) | 8'h80;
            put(v);
            drain();
            check("rate", v[6] ? 8'h01 : 8'h02, {6'h0, rate});
            check("owner", 8'h00, {6'h0, dclk_oe_n, ddat_oe_n});
        end
        put(8'h90);
        cyc(20);
        ctrl = 8'hb0;
        cyc(10);
        put(8'h8f);
        drain();
        tick = 1'b1;
        cyc(4);
        check("clock before start", 8'h00, {7'h0, rclk});
        start_sym = 1'b1;
        cyc(1);
        start_sym = 1'b0;
        slicer = 1'b1;
        cyc(3);
        check("clock after start", 8'h01, {7'h0, rclk});
        check("data out", 8'h01, {7'h0, rdat});
        put(8'h87);
        cyc(4);
        check("clock after disable", 8'h00, {7'h0, rclk});
        drain();
        check("left over", 8'h00, 8'(exp_q.size()));
        finish_test();
    end
endmodule

// ---- radio_port_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Radio serial configuration port
// ----------------------------------------
module radio_port_model (
    input  wire logic       i_clk,
    input  wire logic       i_cs,
    input  wire logic       i_drv_clk,
    input  wire logic       i_drv_clk_oe_n,
    input  wire logic       i_drv_dat,
    input  wire logic       i_drv_dat_oe_n,
    input  wire logic [1:0] i_leg_bits,
    output logic            o_pin_clk,
    output logic            o_pin_dat,
    output logic            o_byte_valid,
    output logic [7:0]      o_byte
);
    logic [7:0] sh = 8'h00;
    logic       clk_prev = 1'b0;
    int         n = 0;

    initial o_byte_valid = 1'b0;
    initial o_byte = 8'h00;

    // host drives levels
    // The host holds defined levels whenever the block lets go of a pin.
    assign o_pin_clk = i_drv_clk_oe_n ? i_leg_bits[0] : i_drv_clk;
    assign o_pin_dat = i_drv_dat_oe_n ? i_leg_bits[1] : i_drv_dat;

    // rising capture, bytes
    // A short byte is dropped when chip select falls, as the radio would.
    always @(posedge i_clk)
    begin
        o_byte_valid <= 1'b0;
        clk_prev <= o_pin_clk;
        if (i_cs !== 1'b1)
            n <= 0;
        else if (o_pin_clk && !clk_prev)
        begin
            sh <= {sh[6:0], o_pin_dat};
            n <= (n == 7) ? 0 : n + 1;
            if (n == 7)
            begin
                o_byte <= {sh[6:0], o_pin_dat};
                o_byte_valid <= 1'b1;
            end
        end
    end
endmodule
